// ===== design/aab_regs.svh
// constants for the add, and and branch execute slice
`ifndef AAB_REGS_SVH
`define AAB_REGS_SVH
`define AAB_OP_ADDI 6'h04
`define AAB_OP_ANDI 6'h0c
`define AAB_OP_ANDHI 6'h2c
`define AAB_OP_BEQ 6'h26
`define AAB_OP_BGE 6'h0e
`define AAB_OP_BGEU 6'h2e
`define AAB_OP_RTYPE 6'h3a
`define AAB_OPX_ADD 6'h31
`define AAB_OPX_AND 6'h0e
`define AAB_OP_LSB 0
`define AAB_OP_MSB 5
`define AAB_IMM_LSB 6
`define AAB_IMM_MSB 21
`define AAB_B_LSB 22
`define AAB_B_MSB 26
`define AAB_A_LSB 27
`define AAB_A_MSB 31
`define AAB_C_LSB 17
`define AAB_C_MSB 21
`define AAB_OPX_LSB 11
`define AAB_OPX_MSB 16
`define AAB_PC_STEP 32'h0000_0004
`endif

// ===== design/aab_pkg.sv
// types for the add, and and branch execute slice
package aab_pkg;
	typedef logic [31:0] aab_word_t;
	typedef logic [4:0] aab_idx_t;
	typedef enum logic [2:0] {
		AAB_K_NONE,
		AAB_K_ADD,
		AAB_K_AND,
		AAB_K_BRANCH
	} aab_kind_e;
	typedef struct packed {
		logic valid;
		logic wr_en;
		aab_idx_t wr_idx;
		aab_word_t wr_data;
		logic pc_load;
		aab_word_t next_pc;
		logic taken;
		logic misaligned;
	} aab_state_s;
endpackage

// ===== design/aab_exec.sv
// execute stage for add, and and conditional branch instructions
`timescale 1ns/1ps
`include "aab_regs.svh"
module aab_exec (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_valid,
	input wire aab_pkg::aab_word_t i_instr,
	input wire aab_pkg::aab_word_t i_pc,
	input wire aab_pkg::aab_word_t i_first_source_register,
	input wire aab_pkg::aab_word_t i_second_source_register,
	output logic o_valid,
	output logic o_wr_en,
	output aab_pkg::aab_idx_t o_wr_idx,
	output aab_pkg::aab_word_t o_wr_data,
	output logic o_pc_load,
	output aab_pkg::aab_word_t o_next_pc,
	output logic o_taken,
	output logic o_misaligned
);
	import aab_pkg::*;

	aab_state_s state;
	aab_state_s next_state;

	logic [5:0] opcode;
	logic [5:0] opx;
	logic [15:0] sixteen_bit_immediate_field;
	aab_word_t imm_sext;
	aab_word_t imm_zext;
	aab_word_t imm_high;
	aab_word_t a;
	aab_word_t b;
	aab_word_t sum_rr;
	aab_word_t sum_ri;
	aab_word_t fall_pc;
	aab_word_t target;
	logic is_rtype;
	logic cond;
	logic is_branch;
	aab_kind_e kind;
	logic [32:0] carry_sum;
	logic [32:0] ovf_sum;

	// fields decoded per the fixed word layouts
	assign opcode = i_instr[`AAB_OP_MSB:`AAB_OP_LSB];
	assign opx = i_instr[`AAB_OPX_MSB:`AAB_OPX_LSB];
	assign sixteen_bit_immediate_field = i_instr[`AAB_IMM_MSB:`AAB_IMM_LSB];
	assign a = i_first_source_register;
	assign b = i_second_source_register;
	assign is_rtype = (opcode == `AAB_OP_RTYPE);
	assign imm_sext = {{16{sixteen_bit_immediate_field[15]}}, sixteen_bit_immediate_field};
	assign imm_zext = {16'h0000, sixteen_bit_immediate_field};
	assign imm_high = {sixteen_bit_immediate_field, 16'h0000};
	// plain modulo sums, no carry kept
	assign sum_rr = a + b;
	assign sum_ri = a + imm_sext;
	assign fall_pc = i_pc + `AAB_PC_STEP;
	assign target = fall_pc + imm_sext;
	// wide sums read only by the carry and overflow checks
	assign carry_sum = {1'b0, a} + {1'b0, b};
	assign ovf_sum = {a[31], a} + {b[31], b};

	always_comb begin
		cond = 1'b0;
		is_branch = 1'b0;
		kind = AAB_K_NONE;
		case (opcode)
			`AAB_OP_BEQ: begin
				is_branch = 1'b1;
				cond = (a == b);
			end
			`AAB_OP_BGE: begin
				is_branch = 1'b1;
				cond = ($signed(a) >= $signed(b));
			end
			`AAB_OP_BGEU: begin
				is_branch = 1'b1;
				cond = (a >= b);
			end
			`AAB_OP_ADDI: kind = AAB_K_ADD;
			`AAB_OP_ANDI: kind = AAB_K_AND;
			`AAB_OP_ANDHI: kind = AAB_K_AND;
			`AAB_OP_RTYPE: begin
				if (opx == `AAB_OPX_ADD) begin
					kind = AAB_K_ADD;
				end else if (opx == `AAB_OPX_AND) begin
					kind = AAB_K_AND;
				end
			end
			default: kind = AAB_K_NONE;
		endcase
		if (is_branch) begin
			kind = AAB_K_BRANCH;
		end
	end

	always_comb begin
		next_state = state;
		next_state.valid = i_valid;
		next_state.wr_en = 1'b0;
		next_state.pc_load = 1'b0;
		next_state.taken = 1'b0;
		next_state.misaligned = 1'b0;
		if (i_valid) begin
			case (kind)
				AAB_K_ADD: begin
					next_state.wr_en = 1'b1;
					if (is_rtype) begin
						next_state.wr_idx = i_instr[`AAB_C_MSB:`AAB_C_LSB];
						next_state.wr_data = sum_rr;
					end else begin
						next_state.wr_idx = i_instr[`AAB_B_MSB:`AAB_B_LSB];
						next_state.wr_data = sum_ri;
					end
				end
				AAB_K_AND: begin
					next_state.wr_en = 1'b1;
					if (is_rtype) begin
						next_state.wr_idx = i_instr[`AAB_C_MSB:`AAB_C_LSB];
						next_state.wr_data = a & b;
					end else begin
						next_state.wr_idx = i_instr[`AAB_B_MSB:`AAB_B_LSB];
						if (opcode == `AAB_OP_ANDHI) begin
							next_state.wr_data = a & imm_high;
						end else begin
							next_state.wr_data = a & imm_zext;
						end
					end
				end
				AAB_K_BRANCH: begin
					// swapped-operand aliases reuse these same comparisons
					next_state.pc_load = 1'b1;
					next_state.taken = cond;
					next_state.next_pc = cond ? target : fall_pc;
					next_state.misaligned = cond && (target[1:0] != 2'b00);
				end
				default: begin
					next_state.wr_en = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign o_valid = state.valid;
	assign o_wr_en = state.wr_en;
	assign o_wr_idx = state.wr_idx;
	assign o_wr_data = state.wr_data;
	assign o_pc_load = state.pc_load;
	assign o_next_pc = state.next_pc;
	assign o_taken = state.taken;
	assign o_misaligned = state.misaligned;

	// write-back checks, expectations rebuilt from the past operands and word fields
	a_rr_sum: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_valid && is_rtype && opx == `AAB_OPX_ADD |=> o_wr_en && o_wr_data == $past(a) + $past(b))
		else $error("register sum wrong");

	a_imm_sum: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_valid && opcode == `AAB_OP_ADDI |=> o_wr_en && o_wr_data == $past(a)
		+ {{16{$past(i_instr[`AAB_IMM_MSB])}}, $past(i_instr[`AAB_IMM_MSB:`AAB_IMM_LSB])}
		&& o_wr_idx == $past(i_instr[`AAB_B_MSB:`AAB_B_LSB]))
		else $error("immediate sum wrong");

	a_rr_and: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_valid && is_rtype && opx == `AAB_OPX_AND |=> o_wr_data == ($past(a) & $past(b))
		&& o_wr_idx == $past(i_instr[`AAB_C_MSB:`AAB_C_LSB]))
		else $error("register and wrong");

	a_hi_and: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_valid && opcode == `AAB_OP_ANDHI |=> o_wr_en
		&& o_wr_data == ($past(a) & {$past(i_instr[`AAB_IMM_MSB:`AAB_IMM_LSB]), 16'h0000}))
		else $error("high and wrong");

	a_lo_and: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_valid && opcode == `AAB_OP_ANDI |=> o_wr_en
		&& o_wr_data == ($past(a) & {16'h0000, $past(i_instr[`AAB_IMM_MSB:`AAB_IMM_LSB])}))
		else $error("low and wrong");

	a_ri_widx: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_valid && (opcode == `AAB_OP_ANDI || opcode == `AAB_OP_ANDHI) |=> o_wr_en
		&& o_wr_idx == $past(i_instr[`AAB_B_MSB:`AAB_B_LSB]))
		else $error("immediate form index wrong");

	a_rr_widx: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_valid && is_rtype && opx == `AAB_OPX_ADD
		|=> o_wr_idx == $past(i_instr[`AAB_C_MSB:`AAB_C_LSB]))
		else $error("register form index wrong");

	a_carry_wrap: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_valid && is_rtype && opx == `AAB_OPX_ADD |=> o_wr_en
		&& (o_wr_data < $past(a)) == $past(carry_sum[32]))
		else $error("carry not visible in wrapped sum");

	a_ovf_sign: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_valid && is_rtype && opx == `AAB_OPX_ADD |=> ((o_wr_data[31] ^ $past(a[31]))
		& (o_wr_data[31] ^ $past(b[31]))) == $past(ovf_sum[32] ^ ovf_sum[31]))
		else $error("overflow not visible in wrapped sum");

	a_wr_source: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		o_wr_en |-> $past(i_valid)
		&& !$past(opcode inside {`AAB_OP_BEQ, `AAB_OP_BGE, `AAB_OP_BGEU}))
		else $error("write without alu word");

	a_wr_hold: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		!o_wr_en && $past(i_reset_n) |-> $stable(o_wr_data) && $stable(o_wr_idx))
		else $error("write data moved while idle");

	// branch checks
	a_beq_path: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_valid && opcode == `AAB_OP_BEQ && a != b |=> !o_taken
		&& o_next_pc == $past(i_pc) + `AAB_PC_STEP)
		else $error("beq fall through wrong");

	a_beq_taken: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_valid && opcode == `AAB_OP_BEQ && a == b |=> o_taken && o_pc_load)
		else $error("beq not taken on equal");

	a_bge_sign: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_valid && opcode == `AAB_OP_BGE |=> o_taken == ($signed($past(a)) >= $signed($past(b))))
		else $error("signed compare wrong");

	a_bge_alias: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_valid && opcode == `AAB_OP_BGE |=> o_taken == !($signed($past(b)) > $signed($past(a))))
		else $error("swapped compare view wrong");

	a_bgeu_cmp: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_valid && opcode == `AAB_OP_BGEU |=> o_taken == ($past(a) >= $past(b)))
		else $error("unsigned compare wrong");

	a_fall_pc: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		o_pc_load && !o_taken |-> o_next_pc == $past(i_pc) + `AAB_PC_STEP)
		else $error("fall through pc wrong");

	a_br_target: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		o_pc_load && o_taken |-> o_next_pc == $past(i_pc) + `AAB_PC_STEP
		+ {{16{$past(i_instr[`AAB_IMM_MSB])}}, $past(i_instr[`AAB_IMM_MSB:`AAB_IMM_LSB])})
		else $error("branch target wrong");

	a_misalign: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		o_misaligned |-> o_taken && o_next_pc[1:0] != 2'b00)
		else $error("misaligned flag wrong");

	a_mis_taken: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		o_pc_load && o_taken |-> o_misaligned == (o_next_pc[1:0] != 2'h0))
		else $error("misaligned target not flagged");

	a_mis_idle: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		!o_pc_load |-> !o_taken && !o_misaligned)
		else $error("branch flags outside a branch");

	a_br_nowrite: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_valid && opcode inside {`AAB_OP_BEQ, `AAB_OP_BGE, `AAB_OP_BGEU}
		|=> o_pc_load && !o_wr_en)
		else $error("branch wrote a register");

	a_pc_source: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		o_pc_load |-> $past(i_valid)
		&& $past(opcode inside {`AAB_OP_BEQ, `AAB_OP_BGE, `AAB_OP_BGEU}))
		else $error("pc load without branch word");

	a_pc_hold: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		!o_pc_load && $past(i_reset_n) |-> $stable(o_next_pc))
		else $error("next pc moved while idle");

	// reset, handshake and refused words
	a_rst_clear: assert property (@(posedge i_sys_clk)
		!i_reset_n |=> !o_valid && !o_wr_en && !o_pc_load && !o_taken && !o_misaligned)
		else $error("outputs not cleared by reset");

	a_valid_pipe: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		$past(i_reset_n) |-> o_valid == $past(i_valid))
		else $error("valid not one cycle late");

	a_refuse_none: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_valid && !(opcode inside {`AAB_OP_ADDI, `AAB_OP_ANDI, `AAB_OP_ANDHI, `AAB_OP_BEQ,
		`AAB_OP_BGE, `AAB_OP_BGEU, `AAB_OP_RTYPE}) |=> o_valid && !o_wr_en && !o_pc_load)
		else $error("unknown opcode acted on");

	// main scenarios reached
	c_taken: cover property (@(posedge i_sys_clk) o_taken);
	c_fall: cover property (@(posedge i_sys_clk) o_pc_load && !o_taken);
	c_mis: cover property (@(posedge i_sys_clk) o_misaligned);
	c_write: cover property (@(posedge i_sys_clk) o_wr_en);
	c_back2back: cover property (@(posedge i_sys_clk) o_wr_en ##1 o_pc_load);
endmodule // aab_exec

// ===== verification/aab_regfile_model.sv
// register file model that feeds operands and takes write-back
`timescale 1ns/1ps
module aab_regfile_model (
	input wire logic i_sys_clk,
	input wire aab_pkg::aab_word_t i_instr,
	input wire logic i_wr_en,
	input wire aab_pkg::aab_idx_t i_wr_idx,
	input wire aab_pkg::aab_word_t i_wr_data,
	output aab_pkg::aab_word_t o_first_source_register,
	output aab_pkg::aab_word_t o_second_source_register
);
	import aab_pkg::*;
	aab_word_t rf [32];
	// operands picked by the index fields of the word
	assign o_first_source_register = rf[i_instr[31:27]];
	assign o_second_source_register = rf[i_instr[26:22]];
	always @(posedge i_sys_clk) begin
		if (i_wr_en) begin
			rf[i_wr_idx] <= i_wr_data;
		end
	end
endmodule // aab_regfile_model

// ===== verification/tb_top.sv
// self-checking bench for the add, and and branch execute slice
`timescale 1ns/1ps
`include "aab_regs.svh"
module tb_top;
	import aab_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic vld = 1'b0;
	aab_word_t ins = 32'h0;
	aab_word_t pc = 32'h0000_1000;
	aab_word_t ra, rb, wd, npc;
	aab_idx_t wi;
	logic ov, we, pl, tk, mis;
	int error_cnt = 0;
	int num_checks = 0;
	initial forever #50 clk = ~clk;
	aab_regfile_model u_aab_regfile_model (.i_sys_clk(clk), .i_instr(ins), .i_wr_en(we),
		.i_wr_idx(wi), .i_wr_data(wd), .o_first_source_register(ra),
		.o_second_source_register(rb));
	aab_exec u_aab_exec (.i_sys_clk(clk), .i_reset_n(rst_n), .i_valid(vld), .i_instr(ins),
		.i_pc(pc), .i_first_source_register(ra), .i_second_source_register(rb),
		.o_valid(ov), .o_wr_en(we), .o_wr_idx(wi), .o_wr_data(wd), .o_pc_load(pl),
		.o_next_pc(npc), .o_taken(tk), .o_misaligned(mis));
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s exp %h seen %h", n, e, s);
		end
	endtask
	task stop_test;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// one word in, result sampled one edge later
	task run(input aab_word_t w);
		@(negedge clk);
		vld = 1'b1;
		ins = w;
		@(negedge clk);
		vld = 1'b0;
		chk("valid", {31'h0, ov}, 32'h1);
	endtask
	task wr(input aab_word_t w, input aab_idx_t i, input aab_word_t d);
		run(w);
		chk("wr_en", {31'h0, we}, 32'h1);
		chk("wr_idx", {27'h0, wi}, {27'h0, i});
		chk("wr_data", wd, d);
	endtask
	function automatic aab_word_t rw(input logic [4:0] a, b, c, input logic [5:0] x);
		return {a, b, c, x, 5'h0, `AAB_OP_RTYPE};
	endfunction
	function automatic aab_word_t iw(input logic [4:0] a, b, input logic [15:0] m,
		input logic [5:0] o);
		return {a, b, m, o};
	endfunction
	task t_arith;
		wr(rw(5'h1, 5'h2, 5'h5, `AAB_OPX_ADD), 5'h5, 32'h8000_0010);
		wr(rw(5'h4, 5'h2, 5'h6, `AAB_OPX_ADD), 5'h6, 32'h0000_001f);
		wr(iw(5'h1, 5'h7, 16'hfff0, `AAB_OP_ADDI), 5'h7, 32'h7fff_ffe0);
		wr(rw(5'h4, 5'h1, 5'h8, `AAB_OPX_AND), 5'h8, 32'h7fff_fff0);
		wr(iw(5'h4, 5'h9, 16'h8234, `AAB_OP_ANDHI), 5'h9, 32'h8234_0000);
		wr(iw(5'h4, 5'ha, 16'h8234, `AAB_OP_ANDI), 5'ha, 32'h0000_8234);
	endtask
	task br(input logic [5:0] o, input logic [4:0] a, b, input logic [15:0] m, input logic t);
		run(iw(a, b, m, o));
		chk("pc_load", {31'h0, pl}, 32'h1);
		chk("taken", {31'h0, tk}, {31'h0, t});
		chk("next_pc", npc, t ? pc + 32'h4 + {{16{m[15]}}, m} : pc + 32'h4);
		chk("misaligned", {31'h0, mis}, {31'h0, t & |m[1:0]});
		chk("wr_en", {31'h0, we}, 32'h0);
	endtask
	task t_branch;
		br(`AAB_OP_BEQ, 5'h2, 5'h2, 16'hfff8, 1'b1);
		br(`AAB_OP_BEQ, 5'h1, 5'h2, 16'h0010, 1'b0);
		br(`AAB_OP_BGE, 5'h4, 5'h2, 16'h0040, 1'b0);
		br(`AAB_OP_BGE, 5'h2, 5'h4, 16'h0040, 1'b1);
		br(`AAB_OP_BGE, 5'h3, 5'h3, 16'h8000, 1'b1);
		br(`AAB_OP_BGEU, 5'h4, 5'h2, 16'h7ffc, 1'b1);
		br(`AAB_OP_BGEU, 5'h2, 5'h4, 16'h0006, 1'b0);
		br(`AAB_OP_BEQ, 5'h2, 5'h2, 16'h0006, 1'b1);
		pc = 32'hffff_fff8;
		br(`AAB_OP_BGEU, 5'h4, 5'h2, 16'h0010, 1'b1);
		pc = 32'h0000_1000;
	endtask
	// alu word then branch word on consecutive edges
	task t_back2back;
		@(negedge clk);
		vld = 1'b1;
		ins = rw(5'h2, 5'h2, 5'hb, `AAB_OPX_ADD);
		@(negedge clk);
		chk("b2b_wr_en", {31'h0, we}, 32'h1);
		chk("b2b_wr_data", wd, 32'h0000_0040);
		chk("b2b_wr_idx", {27'h0, wi}, 32'h0000_000b);
		ins = iw(5'h2, 5'h2, 16'h0010, `AAB_OP_BEQ);
		@(negedge clk);
		vld = 1'b0;
		chk("b2b_taken", {31'h0, tk}, 32'h1);
		chk("b2b_next_pc", npc, pc + 32'h0000_0014);
		chk("b2b_br_wr_en", {31'h0, we}, 32'h0);
	endtask
	// reset dropped over a word in flight, then normal work again
	task t_reset;
		@(negedge clk);
		vld = 1'b1;
		ins = rw(5'h1, 5'h2, 5'hc, `AAB_OPX_ADD);
		rst_n = 1'b0;
		@(negedge clk);
		vld = 1'b0;
		chk("rst_mid_outs", {27'h0, ov, we, pl, tk, mis}, 32'h0);
		rst_n = 1'b1;
		@(negedge clk);
		chk("rst_after_outs", {27'h0, ov, we, pl, tk, mis}, 32'h0);
		wr(rw(5'h2, 5'h2, 5'hc, `AAB_OPX_ADD), 5'hc, 32'h0000_0040);
	endtask
	task t_unknown;
		run(iw(5'h1, 5'h2, 16'h0004, 6'h3f));
		chk("wr_en", {31'h0, we}, 32'h0);
		chk("pc_load", {31'h0, pl}, 32'h0);
	endtask
	initial begin
		u_aab_regfile_model.rf[1] = 32'h7fff_fff0;
		u_aab_regfile_model.rf[2] = 32'h0000_0020;
		u_aab_regfile_model.rf[3] = 32'h8000_0000;
		u_aab_regfile_model.rf[4] = 32'hffff_ffff;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		chk("rst_outs", {29'h0, ov, we, pl}, 32'h0);
		t_arith();
		t_branch();
		t_back2back();
		t_reset();
		t_unknown();
		stop_test();
	end
endmodule // tb_top
